// *** isr_pkg.sv ***
package isr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time base

  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // Recovery after an upstream loss waits this many timeout periods
  localparam int unsigned UP_WAIT_MULT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Switch link service commands seen on a port

  typedef enum logic [4:0] {
    ILS_ELP,
    ILS_EFP,
    ILS_DIA,
    ILS_RDI,
    ILS_HLO,
    ILS_LSU,
    ILS_LSA,
    ILS_BF,
    ILS_RCF,
    ILS_ESC,
    ILS_ACA,
    ILS_RCA,
    ILS_SFC,
    ILS_UFC,
    ILS_SW_RSCN,
    ILS_DRLIR,
    ILS_CEC,
    ILS_ESS,
    ILS_MRRA,
    ILS_STR,
    ILS_EVFP,
    ILS_EACA,
    ILS_ESFC,
    ILS_EUFC,
    ILS_ERCA,
    ILS_TCO,
    ILS_OTHER
  } isr_ils_t;

  // What the transmit port carries
  typedef enum logic [1:0] {
    TX_NONE,
    TX_REQ,
    TX_ACC,
    TX_RJT
  } isr_tx_kind_t;

  ////////////////////////////////////////////////////////////////////////////
  // Isolation cause inputs, one bit each

  localparam int unsigned ISO_LINK_PARAM = 0;
  localparam int unsigned ISO_RDI_NORETRY = 1;
  localparam int unsigned ISO_NO_DAM     = 2;
  localparam int unsigned ISO_ZONE_FAIL  = 3;
  localparam int unsigned ISO_W          = 4;

  localparam logic [7:0] CODE_NONE = 8'h00;

  // Commands refused outright under static domain assignment
  function automatic logic isr_is_cfg_ils(input isr_ils_t c);
    isr_is_cfg_ils = (c == ILS_EFP) || (c == ILS_BF) || (c == ILS_RCF) ||
                     (c == ILS_DIA) || (c == ILS_RDI);
  endfunction

endpackage

// *** isr_timer.sv ***
`timescale 1ns/1ns
module isr_timer
  import isr_pkg::*;
#(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Control
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] load,
  // Status
  output logic              busy,
  output logic              expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         exp;
  } isr_tm_t;

  isr_tm_t s_reg;
  isr_tm_t s_next;

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  always_comb begin
    s_next     = s_reg;
    s_next.exp = 1'b0;
    // A restart wins over a stop in the same cycle
    if (start) begin
      s_next.cnt  = load;
      s_next.busy = 1'b1;
    end else if (stop) begin
      s_next.busy = 1'b0;
    end else if (s_reg.busy) begin
      if (s_reg.cnt <= ONE) begin
        s_next.busy = 1'b0;
        s_next.exp  = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - ONE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy    = s_reg.busy;
  assign expired = s_reg.exp;

endmodule

// *** isr_pick.sv ***
`timescale 1ns/1ns
module isr_pick #(
  parameter int unsigned N  = 8,
  parameter int unsigned PW = 3
) (
  // Candidate ports
  input  wire logic [N-1:0]  mask,
  // Lowest candidate
  output logic               any,
  output logic [PW-1:0]      idx
);

  // Lowest numbered port wins so the choice is repeatable
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (mask[i]) begin
        any = 1'b1;
        idx = PW'(i);
      end
    end
  end

endmodule

// *** isr_ctrl.sv ***
// Operation
// R1 - Downstream loss: send EFP on alternate link
// R2 - EFP accepted: alternate becomes downstream principal
// R3 - Reject or timeout: start Build Fabric
// R4 - Upstream EFP on alternate: accept, adopt link
// R5 - Upstream loss, no EFP in 2x: rebuild
// R6 - Incompatible or unsupported parameters isolate port
// R7 - Overlapping lists, differing principal: isolate port
// R8 - RDI refused, RCF refused, isolated reject: isolate
// R9 - No domain manager or zoning merge fails: isolate
// R10 - Static mode: reject config commands, isolate
// R11 - Isolated port may exchange and answer ELP
// R12 - Isolated port rejects all other commands
// R13 - Isolated link credit one, no alternate
// R14 - No Class N routing over isolated link
// R15 - ELP origination or reinit ends isolation
// R16 - Bridge answers ELP, never forwards it
// R17 - Bridge forwards every other command unchanged
// R18 - Per-port flag and timer, shared timeout
`timescale 1ns/1ns
module isr_ctrl
  import isr_pkg::*;
#(
  parameter int unsigned N        = 8,
  parameter int unsigned PW       = 3,
  parameter int unsigned FSTOV_MS = 5000,
  parameter logic [7:0]  RSN_UNABLE = 8'h01,
  parameter logic [7:0]  EXP_ISOLATED = 8'h01
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Mode straps from switch control
  input  wire logic              recov_en,
  input  wire logic              static_dom,
  input  wire logic              bridge_mode,
  input  wire logic              rcf_refuse,
  // Principal link assignment
  input  wire logic              dn_set,
  input  wire logic [PW-1:0]     dn_set_port,
  input  wire logic              up_set,
  input  wire logic [PW-1:0]     up_set_port,
  input  wire logic [N-1:0]      alt_dn,
  input  wire logic [N-1:0]      alt_up,
  // Link failure
  input  wire logic              link_fail,
  input  wire logic [PW-1:0]     link_fail_port,
  // Received link service
  input  wire logic              rx_valid,
  input  wire logic [PW-1:0]     rx_port,
  input  isr_pkg::isr_ils_t      rx_code,
  input  wire logic              rx_reply,
  input  wire logic              rx_acc,
  input  wire logic              rx_rjt_iso,
  input  wire logic              rx_efp_bad,
  input  wire logic              rx_list_nz,
  input  wire logic              ret_list_nz,
  input  wire logic              lists_overlap,
  input  wire logic              name_differs,
  // Isolation causes and exits
  input  wire logic [ISO_W-1:0]  iso_ev,
  input  wire logic [PW-1:0]     iso_ev_port,
  input  wire logic              elp_orig,
  input  wire logic [PW-1:0]     elp_orig_port,
  input  wire logic              port_init,
  input  wire logic [PW-1:0]     port_init_port,
  // Transmit
  output logic                   tx_valid,
  output isr_pkg::isr_tx_kind_t  tx_kind,
  output logic [PW-1:0]          tx_port,
  output isr_pkg::isr_ils_t      tx_code,
  output logic [7:0]             tx_rsn,
  output logic [7:0]             tx_exp,
  // Forward and pass up
  output logic                   fwd_valid,
  output logic                   pass_valid,
  output logic [PW-1:0]          rx_port_q,
  output isr_pkg::isr_ils_t      rx_code_q,
  // Fabric events and link state
  output logic                   build_fabric,
  output logic [N-1:0]           isolated,
  output logic [N-1:0]           credit_one,
  output logic [N-1:0]           class_n_block,
  output logic                   dn_ok,
  output logic [PW-1:0]          dn_prin,
  output logic                   up_ok,
  output logic [PW-1:0]          up_prin
);

  ////////////////////////////////////////////////////////////////////////////
  // Timeout constants

  localparam longint unsigned FS_CYC =
    longint'(FSTOV_MS) * longint'(CYC_PER_MS);
  localparam int unsigned TW = $clog2(UP_WAIT_MULT * FS_CYC + 1);
  localparam logic [TW-1:0] LOAD_SHORT = TW'(FS_CYC);
  localparam logic [TW-1:0] LOAD_LONG  = TW'(UP_WAIT_MULT * FS_CYC);
  localparam logic [N-1:0]  ONE_HOT0   = {{(N-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [N-1:0]  iso;
    logic [N-1:0]  cred1;
    logic [N-1:0]  blk;
    logic          tx_v;
    isr_tx_kind_t  tx_kind;
    logic [PW-1:0] tx_port;
    isr_ils_t      tx_code;
    logic [7:0]    rsn;
    logic [7:0]    expl;
    logic          fwd_v;
    logic          pass_v;
    logic [PW-1:0] rxp;
    isr_ils_t      rxc;
    logic          bf;
    logic          dn_ok;
    logic [PW-1:0] dn_prin;
    logic          up_ok;
    logic [PW-1:0] up_prin;
    logic          dn_wait;
    logic          dn_send;
    logic [PW-1:0] dn_sub;
    logic          up_wait;
    logic [PW-1:0] up_fail;
    logic          elp_pend;
    logic [PW-1:0] elp_port;
  } isr_st_t;

  isr_st_t s_reg;
  isr_st_t s_next;

  logic [N-1:0]  tm_start;
  logic [N-1:0]  tm_stop;
  logic [N-1:0]  tm_long;
  logic [N-1:0]  tm_busy;
  logic [N-1:0]  tm_exp;
  logic [N-1:0]  iso_set;
  logic [N-1:0]  iso_clr;
  logic [N-1:0]  dn_cand;
  logic          dn_any;
  logic [PW-1:0] dn_pick;
  logic          efp_conflict;
  logic          up_alt_efp;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port recovery timers

  for (genvar g = 0; g < N; g++) begin : g_tm
    isr_timer #(.W(TW)) u_tm (
      .clock   (clock),
      .rst     (rst),
      .start   (tm_start[g]),
      .stop    (tm_stop[g]),
      .load    (tm_long[g] ? LOAD_LONG : LOAD_SHORT), // R18
      .busy    (tm_busy[g]),
      .expired (tm_exp[g])
    );
  end

  // Substitute must reach the same switch, not be the dead link, not isolated
  assign dn_cand = alt_dn & ~s_reg.iso & ~(ONE_HOT0 << link_fail_port);

  isr_pick #(.N(N), .PW(PW)) u_pick (
    .mask (dn_cand),
    .any  (dn_any),
    .idx  (dn_pick)
  );

  assign efp_conflict = rx_list_nz && ret_list_nz && lists_overlap &&
                        name_differs; // R7

  assign up_alt_efp = recov_en && alt_up[rx_port] &&
                      ((s_reg.up_ok && rx_port != s_reg.up_prin) ||
                       s_reg.up_wait);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next        = s_reg;
    tm_start      = '0;
    tm_stop       = '0;
    tm_long       = '0;
    iso_set       = '0;
    iso_clr       = '0;
    s_next.tx_v   = 1'b0;
    s_next.tx_kind = TX_NONE;
    s_next.rsn    = CODE_NONE;
    s_next.expl   = CODE_NONE;
    s_next.fwd_v  = 1'b0;
    s_next.pass_v = 1'b0;
    s_next.bf     = 1'b0;

    if (dn_set) begin
      s_next.dn_ok   = 1'b1;
      s_next.dn_prin = dn_set_port;
    end
    if (up_set) begin
      s_next.up_ok   = 1'b1;
      s_next.up_prin = up_set_port;
    end

    if (port_init) begin
      iso_clr[port_init_port] = 1'b1; // R15
    end
    if (elp_orig && !s_reg.elp_pend) begin
      s_next.elp_pend = 1'b1;
      s_next.elp_port = elp_orig_port;
    end

    if (iso_ev[ISO_LINK_PARAM]) begin
      iso_set[iso_ev_port] = 1'b1; // R6
    end
    if (iso_ev[ISO_RDI_NORETRY]) begin
      iso_set[iso_ev_port] = 1'b1; // R8
    end
    if (iso_ev[ISO_NO_DAM] || iso_ev[ISO_ZONE_FAIL]) begin
      iso_set[iso_ev_port] = 1'b1; // R9
    end

    ////////////////////////////////////////////////////////////////////////
    // Received traffic

    if (rx_valid) begin
      s_next.rxp = rx_port;
      s_next.rxc = rx_code;
      s_next.tx_port = rx_port;
      s_next.tx_code = rx_code;
      if (rx_reply) begin
        if (!rx_acc && rx_rjt_iso) begin
          iso_set[rx_port] = 1'b1; // R8
        end
        if (s_reg.dn_wait && rx_port == s_reg.dn_sub &&
            rx_code == ILS_EFP && !s_reg.dn_send) begin
          s_next.dn_wait = 1'b0;
          tm_stop[rx_port] = 1'b1;
          if (rx_acc) begin
            s_next.dn_ok   = 1'b1; // R2
            s_next.dn_prin = s_reg.dn_sub; // R2
          end else begin
            s_next.bf = 1'b1; // R3
          end
        end else begin
          s_next.pass_v = 1'b1;
        end
      end else if (bridge_mode) begin
        if (rx_code == ILS_ELP) begin
          s_next.tx_v    = 1'b1; // R16
          s_next.tx_kind = TX_ACC; // R16
        end else begin
          s_next.fwd_v = 1'b1; // R17
        end
      end else if (s_reg.iso[rx_port]) begin
        s_next.tx_v = 1'b1;
        if (rx_code == ILS_ELP) begin
          s_next.tx_kind = TX_ACC; // R11
        end else begin
          s_next.tx_kind = TX_RJT; // R12
          s_next.rsn     = RSN_UNABLE; // R12
          s_next.expl    = EXP_ISOLATED; // R12
        end
      end else if ((static_dom && isr_is_cfg_ils(rx_code)) ||
                   (rx_code == ILS_EFP && (rx_efp_bad || efp_conflict)) ||
                   (rx_code == ILS_RCF && rcf_refuse)) begin
        // R10 R6 R7 R8
        s_next.tx_v      = 1'b1;
        s_next.tx_kind   = TX_RJT;
        s_next.rsn       = RSN_UNABLE;
        s_next.expl      = EXP_ISOLATED;
        iso_set[rx_port] = 1'b1;
      end else if (rx_code == ILS_EFP && up_alt_efp) begin
        s_next.tx_v    = 1'b1; // R4
        s_next.tx_kind = TX_ACC; // R4
        s_next.up_ok   = 1'b1; // R4
        s_next.up_prin = rx_port; // R4
        if (s_reg.up_wait) begin
          s_next.up_wait = 1'b0;
          tm_stop[s_reg.up_fail] = 1'b1;
        end
      end else begin
        s_next.pass_v = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Originated requests, after any answer due this cycle

    if (!s_next.tx_v && s_reg.elp_pend) begin
      s_next.tx_v      = 1'b1; // R11
      s_next.tx_kind   = TX_REQ;
      s_next.tx_code   = ILS_ELP;
      s_next.tx_port   = s_reg.elp_port;
      s_next.elp_pend  = 1'b0;
      iso_clr[s_reg.elp_port] = 1'b1; // R15
    end else if (!s_next.tx_v && s_reg.dn_send) begin
      s_next.tx_v    = 1'b1; // R1
      s_next.tx_kind = TX_REQ;
      s_next.tx_code = ILS_EFP;
      s_next.tx_port = s_reg.dn_sub;
      s_next.dn_send = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Principal link loss; a bridge takes no part in fabric recovery

    if (link_fail && !bridge_mode) begin
      if (s_reg.dn_ok && link_fail_port == s_reg.dn_prin) begin
        s_next.dn_ok = 1'b0;
        if (recov_en && dn_any) begin
          s_next.dn_sub  = dn_pick; // R1
          s_next.dn_wait = 1'b1;
          s_next.dn_send = 1'b1; // R1
          tm_start[dn_pick] = 1'b1; // R1
        end else begin
          s_next.bf = 1'b1;
        end
      end
      if (s_reg.up_ok && link_fail_port == s_reg.up_prin) begin
        s_next.up_ok = 1'b0;
        if (recov_en) begin
          s_next.up_wait = 1'b1; // R5
          s_next.up_fail = link_fail_port;
          tm_start[link_fail_port] = 1'b1; // R5
          tm_long[link_fail_port]  = 1'b1; // R5
        end else begin
          s_next.bf = 1'b1;
        end
      end
    end

    // The send deadline and the answer wait share one timeout period
    for (int i = 0; i < N; i++) begin
      if (tm_exp[i]) begin
        if (s_reg.dn_wait && s_reg.dn_sub == PW'(i)) begin
          s_next.dn_wait = 1'b0;
          s_next.dn_send = 1'b0;
          s_next.bf      = 1'b1; // R3
        end
        if (s_reg.up_wait && s_reg.up_fail == PW'(i)) begin
          s_next.up_wait = 1'b0;
          s_next.bf      = 1'b1; // R5
        end
      end
    end

    // Set wins over clear so a late cause is never lost
    s_next.iso   = (s_reg.iso & ~iso_clr) | iso_set; // R18
    s_next.cred1 = s_next.iso; // R13
    s_next.blk   = s_next.iso; // R14
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tx_valid      = s_reg.tx_v;
  assign tx_kind       = s_reg.tx_kind;
  assign tx_port       = s_reg.tx_port;
  assign tx_code       = s_reg.tx_code;
  assign tx_rsn        = s_reg.rsn;
  assign tx_exp        = s_reg.expl;
  assign fwd_valid     = s_reg.fwd_v;
  assign pass_valid    = s_reg.pass_v;
  assign rx_port_q     = s_reg.rxp;
  assign rx_code_q     = s_reg.rxc;
  assign build_fabric  = s_reg.bf;
  assign isolated      = s_reg.iso;
  assign credit_one    = s_reg.cred1;
  assign class_n_block = s_reg.blk;
  assign dn_ok         = s_reg.dn_ok;
  assign dn_prin       = s_reg.dn_prin;
  assign up_ok         = s_reg.up_ok;
  assign up_prin       = s_reg.up_prin;

endmodule

// *** isr_ctrl_props.sv ***
`timescale 1ns/1ns
module isr_ctrl_props
  import isr_pkg::*;
#(
  parameter int unsigned N            = 8,
  parameter int unsigned PW           = 3,
  parameter logic [7:0]  RSN_UNABLE   = 8'h01,
  parameter logic [7:0]  EXP_ISOLATED = 8'h01
) (
  // Clock, reset and modes
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              recov_en,
  input wire logic              static_dom,
  input wire logic              bridge_mode,
  // Links and failures
  input wire logic [N-1:0]      alt_dn,
  input wire logic [N-1:0]      alt_up,
  input wire logic              link_fail,
  input wire logic [PW-1:0]     link_fail_port,
  input wire logic              port_init,
  input wire logic [PW-1:0]     port_init_port,
  input wire logic [ISO_W-1:0]  iso_ev,
  input wire logic [PW-1:0]     iso_ev_port,
  // Received traffic
  input wire logic              rx_valid,
  input wire logic [PW-1:0]     rx_port,
  input isr_pkg::isr_ils_t      rx_code,
  input wire logic              rx_reply,
  input wire logic              rx_acc,
  input wire logic              rx_rjt_iso,
  input wire logic              rx_efp_bad,
  input wire logic              rx_list_nz,
  input wire logic              ret_list_nz,
  input wire logic              lists_overlap,
  input wire logic              name_differs,
  // Design outputs
  input wire logic              tx_valid,
  input isr_pkg::isr_tx_kind_t  tx_kind,
  input wire logic [PW-1:0]     tx_port,
  input isr_pkg::isr_ils_t      tx_code,
  input wire logic [7:0]        tx_rsn,
  input wire logic [7:0]        tx_exp,
  input wire logic              fwd_valid,
  input isr_pkg::isr_ils_t      rx_code_q,
  input wire logic [N-1:0]      isolated,
  input wire logic [N-1:0]      credit_one,
  input wire logic [N-1:0]      class_n_block,
  input wire logic              dn_ok,
  input wire logic [PW-1:0]     dn_prin,
  input wire logic              up_ok,
  input wire logic [PW-1:0]     up_prin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic rq;
  assign rq = rx_valid && !rx_reply;

  chk_iso_reject: assert property (
    rq && rx_code != ILS_ELP && isolated[rx_port] && !bridge_mode |=>
    tx_valid && tx_kind == TX_RJT && tx_rsn == RSN_UNABLE &&
    tx_exp == EXP_ISOLATED && tx_port == $past(rx_port))
    else $error("no isolated reject");
  chk_static_rej: assert property (
    rq && static_dom && !bridge_mode && isr_is_cfg_ils(rx_code) |=>
    tx_valid && tx_kind == TX_RJT && tx_exp == EXP_ISOLATED &&
    isolated[$past(rx_port)])
    else $error("no static reject");
  chk_credit_route: assert property (
    credit_one == isolated && class_n_block == isolated)
    else $error("credit or route mismatch");
  chk_bridge_fwd: assert property (
    rq && bridge_mode && rx_code != ILS_ELP && !isolated[rx_port] |=>
    fwd_valid && rx_code_q == $past(rx_code) &&
    !(tx_valid && tx_kind == TX_REQ))
    else $error("no bridge forward");
  chk_bridge_elp: assert property (
    rq && bridge_mode && rx_code == ILS_ELP |=>
    !fwd_valid && tx_valid && tx_kind == TX_ACC)
    else $error("bridge ELP wrong");
  chk_up_adopt: assert property (
    rq && recov_en && up_ok && !bridge_mode && !static_dom &&
    rx_port != up_prin &&
    rx_code == ILS_EFP && alt_up[rx_port] && !isolated[rx_port] &&
    !rx_efp_bad && !lists_overlap |=> tx_valid && tx_kind == TX_ACC &&
    up_ok && up_prin == $past(rx_port))
    else $error("no upstream adopt");
  chk_iso_rx: assert property (
    rx_valid && !bridge_mode && ((rq && rx_code == ILS_EFP &&
    (rx_efp_bad || (rx_list_nz && ret_list_nz && lists_overlap &&
    name_differs))) || (rx_reply && !rx_acc && rx_rjt_iso)) |=>
    isolated[$past(rx_port)])
    else $error("rx cause not isolated");
  chk_iso_cause: assert property (
    iso_ev != '0 |=> isolated[$past(iso_ev_port)])
    else $error("cause ignored");
  chk_init_clear: assert property (
    port_init && iso_ev == '0 && !rx_valid |=>
    !isolated[$past(port_init_port)])
    else $error("reinit kept isolation");
  chk_down_send: assert property (
    recov_en && !bridge_mode && link_fail && dn_ok &&
    link_fail_port == dn_prin && !alt_dn[link_fail_port] &&
    (alt_dn & ~isolated) != '0 |-> ##[2:40]
    (tx_valid && tx_kind == TX_REQ && tx_code == ILS_EFP))
    else $error("no substitute EFP");
endmodule

bind isr_ctrl isr_ctrl_props #(.N(N), .PW(PW), .RSN_UNABLE(RSN_UNABLE),
  .EXP_ISOLATED(EXP_ISOLATED)) isr_ctrl_props_i (.*);

// *** isr_peer.sv ***
`timescale 1ns/1ns
module isr_peer
  import isr_pkg::*;
(
  // Clock and design transmit side
  input  wire logic             clock,
  input  wire logic             tx_valid,
  input  isr_pkg::isr_tx_kind_t tx_kind,
  input  wire logic [2:0]       tx_port,
  input  isr_pkg::isr_ils_t     tx_code,
  // Answer: 0 silent, 1 accept, 2 reject; delay in cycles
  input  wire logic [1:0]       mode,
  input  wire logic [3:0]       dly,
  // Frames toward the design
  output logic                  rx_valid,
  output logic [2:0]            rx_port,
  output isr_pkg::isr_ils_t     rx_code,
  output logic                  rx_reply,
  output logic                  rx_acc,
  output logic [5:0]            rx_flg
);
  logic [2:0] hold_port;

  initial begin
    {rx_valid, rx_port, rx_reply, rx_acc, rx_flg} = '0;
    rx_code = ILS_OTHER;
  end

  // Frame stands one cycle
  task automatic send(input logic [2:0] p, input isr_ils_t c,
                      input logic rp, input logic ac, input logic [5:0] f);
    rx_valid = 1'b1;
    rx_port = p;
    rx_code = c;
    rx_reply = rp;
    rx_acc = ac;
    rx_flg = f;
    @(posedge clock);
    #2;
    rx_valid = 1'b0;
    // Released qualifiers flip so a stale value can never match
    rx_port = ~p;
    rx_reply = ~rp;
    rx_acc = ~ac;
    rx_flg = ~f;
  endtask

  always begin
    @(posedge clock);
    #2;
    // Silent mode leaves the design to its own timeout
    if (tx_valid === 1'b1 && tx_kind === TX_REQ && tx_code === ILS_EFP &&
        mode != 2'h0) begin
      hold_port = tx_port;
      repeat (dly) @(posedge clock);
      #2;
      send(hold_port, ILS_EFP, 1'b1, mode == 2'h1, 6'h00);
    end
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import isr_pkg::*;
  localparam int         FS    = CYC_PER_MS;
  localparam int         LIMIT = 3 * FS + 6000;
  localparam logic [7:0] RSN   = 8'h0a;
  localparam logic [7:0] EXPI  = 8'h05;

  logic         clock = 1'b0, rst = 1'b1, recov_en = 1'b0;
  logic         static_dom = 1'b0, bridge_mode = 1'b0, rcf_refuse = 1'b0;
  logic         dn_set = 1'b0, up_set = 1'b0, link_fail = 1'b0;
  logic         elp_orig = 1'b0, port_init = 1'b0;
  logic [2:0]   dn_set_port = 3'h0, up_set_port = 3'h0;
  logic [2:0]   link_fail_port = 3'h0, iso_ev_port = 3'h0;
  logic [2:0]   elp_orig_port = 3'h0, port_init_port = 3'h0;
  logic [7:0]   alt_dn = 8'h00, alt_up = 8'h00;
  logic [3:0]   iso_ev = 4'h0, peer_dly = 4'h3;
  logic [1:0]   peer_mode = 2'h1;
  logic         rx_valid, rx_reply, rx_acc, tx_valid, fwd_valid, pass_valid;
  logic         build_fabric, dn_ok, up_ok;
  logic [2:0]   rx_port, tx_port, rx_port_q, dn_prin, up_prin;
  logic [5:0]   rx_flg;
  logic [7:0]   tx_rsn, tx_exp, isolated, credit_one, class_n_block;
  isr_ils_t     rx_code, tx_code, rx_code_q, c;
  isr_tx_kind_t tx_kind;
  isr_ils_t     cfg [5] = '{ILS_EFP, ILS_BF, ILS_RCF, ILS_DIA, ILS_RDI};
  int           failures = 0, check_count = 0, cyc = 0, n, p;

  isr_ctrl #(.FSTOV_MS(1), .RSN_UNABLE(RSN), .EXP_ISOLATED(EXPI)) isr_ctrl_i (
    .*, .rx_rjt_iso(rx_flg[0]), .rx_efp_bad(rx_flg[1]),
    .rx_list_nz(rx_flg[2]), .ret_list_nz(rx_flg[3]),
    .lists_overlap(rx_flg[4]), .name_differs(rx_flg[5]));
  isr_peer isr_peer_i (.*, .mode(peer_mode), .dly(peer_dly));

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic step;
    @(posedge clock);
    #2;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a transmit
  task automatic ans(input isr_tx_kind_t k, input logic [2:0] pt,
                     input isr_ils_t cd, input logic [7:0] e);
    int i;
    i = 0;
    while (tx_valid !== 1'b1 && i < 60) begin
      step();
      i++;
    end
    chk(tx_valid, 8'h01);
    chk(tx_kind, k);
    chk(tx_port, pt);
    chk(tx_code, cd);
    chk(tx_exp, e);
    chk(tx_rsn, (e == 8'h00) ? 8'h00 : RSN);
  endtask

  task automatic wait_bf(output int t);
    t = 0;
    while (build_fabric !== 1'b1 && t < 3 * FS) begin
      step();
      t++;
    end
  endtask

  task automatic fail(input logic [2:0] pt);
    link_fail = 1'b1;
    link_fail_port = pt;
    step();
    link_fail = 1'b0;
  endtask

  task automatic init(input logic [2:0] pt);
    port_init = 1'b1;
    port_init_port = pt;
    step();
    port_init = 1'b0;
  endtask

  initial begin
    void'($urandom(32'h0812));
    repeat (16) @(posedge clock);
    #2;
    rst = 1'b0;
    step();
    chk(isolated, 8'h00);
    chk(tx_valid, 8'h00);
    recov_en = 1'b1;
    alt_dn = 8'h0c;
    alt_up = 8'h40;
    dn_set = 1'b1;
    dn_set_port = 3'd1;
    up_set = 1'b1;
    up_set_port = 3'd5;
    step();
    dn_set = 1'b0;
    up_set = 1'b0;
    step();
    isr_peer_i.send(3'd6, ILS_EFP, 1'b0, 1'b0, 6'h00);
    ans(TX_ACC, 3'd6, ILS_EFP, 8'h00);
    step();
    chk(up_prin, 8'd6);
    fail(3'd1);
    ans(TX_REQ, 3'd2, ILS_EFP, 8'h00);
    repeat (8) step();
    chk({dn_ok, dn_prin}, 8'h0a);
    alt_dn = 8'h08;
    peer_mode = 2'h2;
    fail(3'd2);
    ans(TX_REQ, 3'd3, ILS_EFP, 8'h00);
    wait_bf(n);
    chk(n < 20, 8'h01);
    peer_mode = 2'h0;
    dn_set = 1'b1;
    dn_set_port = 3'd3;
    step();
    dn_set = 1'b0;
    alt_dn = 8'h10;
    fail(3'd3);
    ans(TX_REQ, 3'd4, ILS_EFP, 8'h00);
    wait_bf(n);
    chk(n + 12 > FS && n < FS + 12, 8'h01);
    alt_up = 8'h80;
    fail(3'd6);
    wait_bf(n);
    chk(n + 12 > 2 * FS && n < 2 * FS + 12, 8'h01);
    for (int b = 0; b < 4; b++) begin
      iso_ev = 4'h1 << b;
      iso_ev_port = b[2:0];
      step();
      iso_ev = 4'h0;
      step();
      chk(isolated, 8'h01 << b);
      chk(credit_one & class_n_block, 8'h01 << b);
      init(b[2:0]);
      step();
      chk(isolated, 8'h00);
    end
    isr_peer_i.send(3'd0, ILS_EFP, 1'b0, 1'b0, 6'h1c);
    chk(pass_valid, 8'h01);
    step();
    chk(isolated, 8'h00);
    isr_peer_i.send(3'd0, ILS_EFP, 1'b0, 1'b0, 6'h3c);
    step();
    chk(isolated, 8'h01);
    isr_peer_i.send(3'd1, ILS_EFP, 1'b0, 1'b0, 6'h02);
    step();
    chk(isolated, 8'h03);
    isr_peer_i.send(3'd2, ILS_RDI, 1'b1, 1'b0, 6'h01);
    step();
    chk(isolated, 8'h07);
    rcf_refuse = 1'b1;
    isr_peer_i.send(3'd5, ILS_RCF, 1'b0, 1'b0, 6'h00);
    ans(TX_RJT, 3'd5, ILS_RCF, EXPI);
    step();
    chk(isolated, 8'h27);
    rcf_refuse = 1'b0;
    repeat (20) begin
      c = isr_ils_t'($urandom_range(26, 1));
      isr_peer_i.send(3'd0, c, 1'b0, 1'b0, 6'($urandom_range(63, 0)));
      ans(TX_RJT, 3'd0, c, EXPI);
      step();
    end
    isr_peer_i.send(3'd0, ILS_ELP, 1'b0, 1'b0, 6'h00);
    ans(TX_ACC, 3'd0, ILS_ELP, 8'h00);
    step();
    elp_orig = 1'b1;
    elp_orig_port = 3'd0;
    step();
    elp_orig = 1'b0;
    ans(TX_REQ, 3'd0, ILS_ELP, 8'h00);
    step();
    chk(isolated[0], 8'h00);
    static_dom = 1'b1;
    foreach (cfg[i]) begin
      init(3'd4);
      isr_peer_i.send(3'd4, cfg[i], 1'b0, 1'b0, 6'h00);
      ans(TX_RJT, 3'd4, cfg[i], EXPI);
      step();
      chk(isolated[4], 8'h01);
    end
    static_dom = 1'b0;
    for (int k = 0; k < 8; k++) init(k[2:0]);
    bridge_mode = 1'b1;
    for (int k = 1; k < 26; k++) begin
      p = $urandom_range(7, 0);
      isr_peer_i.send(p[2:0], isr_ils_t'(k), 1'b0, 1'b0, 6'h00);
      chk({fwd_valid, rx_port_q}, {5'h01, p[2:0]});
      chk(rx_code_q, k[7:0]);
      step();
    end
    isr_peer_i.send(3'd3, ILS_ELP, 1'b0, 1'b0, 6'h00);
    chk(fwd_valid, 8'h00);
    ans(TX_ACC, 3'd3, ILS_ELP, 8'h00);
    tally_and_finish();
  end
endmodule
